// ===== rtl/tpop_pkg.sv
/*
  Shared constants for the timer port and output port pin logic.
  Assumes a single 50 MHz clock and synchronous active-low reset.
*/
package tpop_pkg;
  // compare-driven lines of the timer port
  localparam int LINE_LO = 3;
  localparam int LINE_HI = 6;
  localparam int N_CMP = 4;
  // values after reset
  localparam logic [4:0] GP_LATCH_RST = 5'h00;
  localparam logic [3:0] LINE_RST = 4'h0;
  localparam logic [7:0] OP_LATCH_RST = 8'hFF;
  // compare_out_mode:compare_out_level actions
  localparam logic [1:0] OM_OFF = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_LOW = 2'h2;
  localparam logic [1:0] OM_HIGH = 2'h3;
endpackage

// ===== rtl/tpop_outport.sv
/*
  Output-only port: eight fixed outputs, general-purpose latch in
  single-chip mode, high-order address latch in expanded mode.
  Assumes edge strobes come from the parent, synchronous to ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module tpop_outport #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic ph2Fall, // falling edge of phase-2 clock
  input wire logic expandedModeSelect, // 1 = expanded mode
  input wire logic addressStrobe, // address strobe level
  input wire logic [WIDTH-1:0] highAddr, // high-order address
  input wire logic outportWriteStrobe, // write request pulse
  input wire logic [WIDTH-1:0] writeData, // data bus
  input wire logic outportReadReq, // read request pulse
  output logic outportReadEnable, // internal read enable
  output logic [WIDTH-1:0] outportReadData, // read-back data
  output logic externalAccess, // access sent to external bus
  output logic [WIDTH-1:0] outportPins // port pins
);
  import tpop_pkg::*;

  logic [WIDTH-1:0] pinQ, pinD, pendQ;
  logic pendValidQ, applyNow;

  // pins show the complement of the latch, so latch set means low
  assign applyNow = ph2Fall & pendValidQ & ~outportReadReq;
  always_comb begin
    pinD = pinQ;
    if (expandedModeSelect) begin
      if (addressStrobe)
        pinD = highAddr;
    end else if (applyNow) begin
      pinD = pendQ;
    end
  end

  // pin latch; reset sets the latch, all lines low
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      pinQ <= ~OP_LATCH_RST[WIDTH-1:0];
    else
      pinQ <= pinD;
  end

  // a write waits for the phase-2 falling edge; new write wins
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pendQ <= ~OP_LATCH_RST[WIDTH-1:0];
      pendValidQ <= 1'b0;
    end else if (expandedModeSelect) begin
      pendValidQ <= 1'b0; // writes go external instead
    end else if (outportWriteStrobe) begin
      pendQ <= writeData;
      pendValidQ <= 1'b1;
    end else if (applyNow) begin
      pendValidQ <= 1'b0;
    end
  end

  // read path and external access flag
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      outportReadEnable <= 1'b0;
      outportReadData <= '0;
      externalAccess <= 1'b0;
    end else begin
      outportReadEnable <= outportReadReq & ~expandedModeSelect;
      externalAccess <= expandedModeSelect &
        (outportReadReq | outportWriteStrobe);
      if (outportReadReq & ~expandedModeSelect)
        outportReadData <= pinQ;
    end
  end
  assign outportPins = pinQ;

  a_ext_no_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    expandedModeSelect && outportReadReq |=>
      !outportReadEnable && externalAccess)
    else $error("expanded read raised internal read enable");
  a_read_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !expandedModeSelect && outportReadReq |=>
      outportReadEnable && outportReadData == $past(pinQ))
    else $error("single-chip read data not from latch");
  a_reset_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(rst_n) |-> outportPins == '0)
    else $error("outport pins not low after reset");
  a_addr_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    expandedModeSelect && addressStrobe |=>
      outportPins == $past(highAddr))
    else $error("address not passed while strobe high");
  a_addr_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    expandedModeSelect && !addressStrobe |=> $stable(outportPins))
    else $error("address moved while strobe low");
  // the reset edge itself moves the pins; it is not a write
  a_write_ph2: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(rst_n) && !$stable(outportPins) &&
      !$past(expandedModeSelect) |-> $past(ph2Fall))
    else $error("single-chip pins changed off phase-2 fall");
  a_no_change_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !expandedModeSelect && outportReadReq |=>
      $stable(outportPins))
    else $error("outport data changed during its read");
endmodule
`default_nettype wire

// ===== rtl/tpop_top.sv
/*
  Timer port (lines 3..7, output compare override) and output-only
  port pin logic. Bus clock, phase-2 clock and address strobe arrive
  as levels synchronous to ref_clk; bus clock and phase-2 clock edges are found here.
*/
// Functional notes
// - reads of lines 3..6 return the internal latch, not the pin.
// - lines 3..6 take general latch at sync strobe if no timer owns.
// - compare1 mask bit set gives channel 1 the line, blocks latch.
// - channels 2..5 own their line when mode:level is not 00.
// - channel 1 match or force loads value bits at sync strobe.
// - channel 1 beats another channel changing the same line.
// - channel x next state uses mode, level and held previous state.
// - bit 7 reads always return the buffered pin level.
// - bit 7 driver on only when its direction bit is 1.
// - mask7 at 0: line 7 from general latch, reset clears it.
// - mask7 at 1: channel 1 loads value7; writes do not reach it.
// - timer port output changes except direction occur at bus clock fall.
// - bit 7 direction changes act at phase-2 clock fall.
// - output-only port has eight lines that are always outputs.
// - expanded mode outport accesses go external, no read enable.
// - single-chip outport reads return latch ahead of buffers.
// - writes load outport latch; reset sets it, pins low.
// - expanded mode latch passes address while strobe high.
// - outport writes change pins at phase-2 clock fall.
// - outport data never changes in the cycle it is read.
`timescale 1ns/100ps
`default_nettype none
module tpop_top (
  input wire logic ref_clk, // 50 MHz system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic busClk, // bus clock E level
  input wire logic internalPhase2Clock, // phase-2 clock level
  input wire logic timerportReadEnable, // timer port read pulse
  input wire logic timerportWriteStrobe, // timer port write pulse
  input wire logic [7:0] writeData, // data bus
  input wire logic [tpop_pkg::LINE_HI:tpop_pkg::LINE_LO]
    compare1PinMask, // channel 1 mask, lines 6..3
  input wire logic [tpop_pkg::LINE_HI:tpop_pkg::LINE_LO]
    compare1PinValue, // channel 1 data, lines 6..3
  input wire logic compare1MaskBit7, // channel 1 mask, line 7
  input wire logic compare1ValueBit7, // channel 1 data, line 7
  input wire logic [tpop_pkg::LINE_HI:tpop_pkg::LINE_LO]
    compareOutMode, // per line mode bit
  input wire logic [tpop_pkg::LINE_HI:tpop_pkg::LINE_LO]
    compareOutLevel, // per line level bit
  input wire logic compare1Match, // channel 1 match pulse
  input wire logic forceCompare1, // channel 1 force pulse
  input wire logic [tpop_pkg::LINE_HI:tpop_pkg::LINE_LO]
    compareXMatch, // per line match pulse
  input wire logic [tpop_pkg::LINE_HI:tpop_pkg::LINE_LO]
    forceCompareX, // per line force pulse
  input wire logic bit7Direction, // line 7 direction, 1 = out
  input wire logic pin7In, // buffered line 7 pin level
  output logic [7:tpop_pkg::LINE_LO] timerportReadData, // read-back
  output logic [tpop_pkg::LINE_HI:tpop_pkg::LINE_LO]
    timerPinOut, // lines 6..3 drive
  output logic pin7Out, // line 7 output data
  output logic pin7OutEn, // line 7 output enable
  input wire logic expandedModeSelect, // 1 = expanded mode
  input wire logic addressStrobe, // address strobe level
  input wire logic [7:0] highAddr, // high-order address
  input wire logic outportWriteStrobe, // outport write pulse
  input wire logic outportReadReq, // outport read pulse
  output logic outportReadEnable, // outport internal read enable
  output logic [7:0] outportReadData, // outport read-back
  output logic externalAccess, // outport access went external
  output logic [7:0] outportPins // outport pins
);
  import tpop_pkg::*;

  logic busClkQ, ph2Q;
  logic portSyncStrobe, ph2Fall;
  logic [7:LINE_LO] gpLatchQ;
  logic [LINE_HI:LINE_LO] lineQ, lineD;
  logic [LINE_HI:LINE_LO] ocxPendQ, ocxEv, ocxNow, ocxOn;
  logic [LINE_HI:LINE_LO] oc1Wins, tglSel;
  logic oc1PendQ, oc1Ev, oc1Now;
  logic hold7Q, hold7D, dir7Q;
  logic [4:0] readQ;

  // mode:level decode, next line state from previous state
  function automatic logic nextTimerState(
    input logic mode,
    input logic level,
    input logic prev
  );
    logic r;
    r = prev;
    case ({mode, level})
      OM_TOGGLE: r = ~prev;
      OM_LOW: r = 1'b0;
      OM_HIGH: r = 1'b1;
      default: r = prev;
    endcase
    return r;
  endfunction

  // a channel owns its line for any setting other than 00
  function automatic logic [LINE_HI:LINE_LO] ownedLines(
    input logic [LINE_HI:LINE_LO] mode,
    input logic [LINE_HI:LINE_LO] level
  );
    return mode | level;
  endfunction

  // edge detection on the bus clock and phase-2 clock levels
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busClkQ <= 1'b0;
      ph2Q <= 1'b0;
    end else begin
      busClkQ <= busClk;
      ph2Q <= internalPhase2Clock;
    end
  end
  // port sync strobe marks the bus clock falling edge
  assign portSyncStrobe = busClkQ & ~busClk;
  assign ph2Fall = ph2Q & ~internalPhase2Clock;

  // general-purpose latch; stored even while a timer owns the line
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      gpLatchQ <= GP_LATCH_RST;
    else if (timerportWriteStrobe)
      gpLatchQ <= writeData[7:LINE_LO];
  end

  // compare events arrive at any time; hold them to the sync strobe
  assign oc1Ev = compare1Match | forceCompare1;
  assign ocxEv = compareXMatch | forceCompareX;
  assign oc1Now = oc1PendQ | oc1Ev;
  assign ocxNow = ocxPendQ | ocxEv;
  assign ocxOn = ownedLines(compareOutMode, compareOutLevel);

  // pending flags: an event in the strobe cycle is used, not dropped
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      oc1PendQ <= 1'b0;
      ocxPendQ <= '0;
    end else if (portSyncStrobe) begin
      oc1PendQ <= 1'b0;
      ocxPendQ <= '0;
    end else begin
      oc1PendQ <= oc1PendQ | oc1Ev;
      ocxPendQ <= ocxPendQ | ocxEv;
    end
  end

  // channel 1 wins a line it masks whenever it fires
  assign oc1Wins = compare1PinMask & {N_CMP{oc1Now}};
  // helper for checking the toggle path
  assign tglSel = ocxNow & ocxOn & ~oc1Wins &
    ~compareOutMode & compareOutLevel;

  // next state of lines 3..6, only at the sync strobe
  always_comb begin
    lineD = lineQ;
    if (portSyncStrobe) begin
      for (int i = LINE_LO; i <= LINE_HI; i++) begin
        if (oc1Wins[i]) begin
          lineD[i] = compare1PinValue[i];
        end else if (ocxOn[i] && ocxNow[i]) begin
          // previous state is lineQ, held until the clock edge
          lineD[i] = nextTimerState(compareOutMode[i],
            compareOutLevel[i], lineQ[i]);
        end else if (!compare1PinMask[i] && !ocxOn[i]) begin
          lineD[i] = gpLatchQ[i];
        end
      end
    end
  end

  // lines 3..6 output latch
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      lineQ <= LINE_RST;
    else
      lineQ <= lineD;
  end
  assign timerPinOut = lineQ;

  // line 7 data holder: channel 1 or the general latch
  always_comb begin
    hold7D = hold7Q;
    if (portSyncStrobe) begin
      if (compare1MaskBit7) begin
        if (oc1Now)
          hold7D = compare1ValueBit7;
      end else begin
        hold7D = gpLatchQ[7];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      hold7Q <= GP_LATCH_RST[4];
    else
      hold7Q <= hold7D;
  end
  assign pin7Out = hold7Q;

  // direction acts on phase-2 fall, not on the bus clock
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      dir7Q <= 1'b0; // reset leaves line 7 an input
    else if (ph2Fall)
      dir7Q <= bit7Direction;
  end
  assign pin7OutEn = dir7Q;

  // read-back: latch for 3..6, pin level for 7 whatever direction
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      readQ <= '0;
    else if (timerportReadEnable)
      readQ <= {pin7In, lineQ};
  end
  assign timerportReadData = readQ;

  // output-only port
  tpop_outport #(
    .WIDTH(8)
  ) u_outport (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ph2Fall(ph2Fall),
    .expandedModeSelect(expandedModeSelect),
    .addressStrobe(addressStrobe),
    .highAddr(highAddr),
    .outportWriteStrobe(outportWriteStrobe),
    .writeData(writeData),
    .outportReadReq(outportReadReq),
    .outportReadEnable(outportReadEnable),
    .outportReadData(outportReadData),
    .externalAccess(externalAccess),
    .outportPins(outportPins)
  );

  // checks on the timer port
  a_read_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
    timerportReadEnable |=>
      timerportReadData[LINE_HI:LINE_LO] == $past(lineQ))
    else $error("timer port read not from latch");

  a_gp_path: assert property (@(posedge ref_clk) disable iff (!rst_n)
    portSyncStrobe |=> ((lineQ ^ $past(gpLatchQ[LINE_HI:LINE_LO])) &
      $past(~compare1PinMask & ~ocxOn)) == '0)
    else $error("free line did not take general latch");

  a_oc1_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    portSyncStrobe && oc1Now |=>
      ((lineQ ^ $past(compare1PinValue)) &
      $past(compare1PinMask)) == '0)
    else $error("channel 1 value not loaded or not winning");

  a_oc1_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
    portSyncStrobe && !oc1Now |=>
      ((lineQ ^ $past(lineQ)) & $past(compare1PinMask) &
      ~$past(ocxOn & ocxNow)) == '0)
    else $error("masked line moved without a compare");

  a_toggle_prev: assert property (@(posedge ref_clk) disable iff (!rst_n)
    portSyncStrobe |=>
      ((lineQ ^ ~$past(lineQ)) & $past(tglSel)) == '0)
    else $error("toggle did not invert previous state");

  // skip the release edge: the reset edge before it may move the lines
  a_sync_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(rst_n) && (!$stable(lineQ) || !$stable(pin7Out)) |->
      $past(portSyncStrobe))
    else $error("timer line changed off bus clock fall");

  a_dir_ph2: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(rst_n) && !$stable(pin7OutEn) |-> $past(ph2Fall))
    else $error("direction changed off phase-2 fall");

  a_dir_enable: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ph2Fall |=> pin7OutEn == $past(bit7Direction))
    else $error("line 7 enable does not follow direction");

  a_bit7_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    timerportReadEnable |=>
      timerportReadData[7] == $past(pin7In))
    else $error("bit 7 read not from pin");

  a_bit7_gp: assert property (@(posedge ref_clk) disable iff (!rst_n)
    portSyncStrobe && !compare1MaskBit7 |=>
      pin7Out == $past(gpLatchQ[7]))
    else $error("line 7 did not take general latch");

  a_bit7_oc1: assert property (@(posedge ref_clk) disable iff (!rst_n)
    portSyncStrobe && compare1MaskBit7 && !oc1Now |=>
      $stable(pin7Out))
    else $error("general write reached masked line 7");

  a_bit7_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    portSyncStrobe && compare1MaskBit7 && oc1Now |=>
      pin7Out == $past(compare1ValueBit7))
    else $error("line 7 channel 1 value not loaded");
endmodule
`default_nettype wire

// ===== bench/tpop_pin_model.sv
/*
  Far-side model of the line 7 pin: resolves the wire from the port
  driver and an outside driver that the bench switches on and off.
  Assumes pin7OutEn high means the port drives the line.
*/
`timescale 1ns/100ps
`default_nettype none
module tpop_pin_model (
  input wire logic ref_clk, // system clock
  input wire logic pin7Out, // port data
  input wire logic pin7OutEn, // port driver on
  input wire logic extEn, // outside driver on
  input wire logic extLevel, // outside driver level
  output logic pin7In // buffered pin level
);
  logic lineLast_q = 1'b0;
  // remember the wire so a floating line cannot echo the last value
  always_ff @(posedge ref_clk) begin
    lineLast_q <= pin7In;
  end
  // no pull on this line: undriven shows the inverse of the last level
  assign pin7In = pin7OutEn ? pin7Out : (extEn ? extLevel : ~lineLast_q);
endmodule
`default_nettype wire

// ===== bench/testbench.sv
/*
  Self-checking bench for the timer port and output-only port pins.
  Assumes bus clock, phase-2 clock and strobes are driven as levels.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import tpop_pkg::*;
  logic ref_clk, rst_n, busClk, ph2, tRdEn, tWr, c1m7, c1v7, c1Match, fc1;
  logic bit7Dir, pin7In, extEn, extLevel, expMode, aStrobe, oWr, oRd;
  logic pin7Out, pin7OutEn, oRdEn, extAcc;
  logic [7:0] wData, hiAddr, oRdData, oPins;
  logic [LINE_HI:LINE_LO] c1Mask, c1Val, oMode, oLevel, xMatch, fx, tPins;
  logic [7:LINE_LO] tRdData;
  int errors, nTests;

  tpop_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .busClk(busClk),
    .internalPhase2Clock(ph2), .timerportReadEnable(tRdEn),
    .timerportWriteStrobe(tWr), .writeData(wData),
    .compare1PinMask(c1Mask), .compare1PinValue(c1Val),
    .compare1MaskBit7(c1m7), .compare1ValueBit7(c1v7),
    .compareOutMode(oMode), .compareOutLevel(oLevel),
    .compare1Match(c1Match), .forceCompare1(fc1),
    .compareXMatch(xMatch), .forceCompareX(fx),
    .bit7Direction(bit7Dir), .pin7In(pin7In),
    .timerportReadData(tRdData), .timerPinOut(tPins),
    .pin7Out(pin7Out), .pin7OutEn(pin7OutEn),
    .expandedModeSelect(expMode), .addressStrobe(aStrobe),
    .highAddr(hiAddr), .outportWriteStrobe(oWr), .outportReadReq(oRd),
    .outportReadEnable(oRdEn), .outportReadData(oRdData),
    .externalAccess(extAcc), .outportPins(oPins));

  tpop_pin_model pinModel (.ref_clk(ref_clk), .pin7Out(pin7Out),
    .pin7OutEn(pin7OutEn), .extEn(extEn), .extLevel(extLevel),
    .pin7In(pin7In));

  // 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task giveVerdict;
    if (errors == 0 && nTests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
    nTests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, m, seen,
        exp);
    end
  endtask

  task step;
    @(posedge ref_clk);
  endtask

  // bus clock high then low; lines settle one edge after the strobe
  task eFall;
    step;
    busClk <= 1'b1;
    step;
    busClk <= 1'b0;
    step;
    step;
    @(negedge ref_clk);
  endtask

  // phase-2 fall, optionally with an outport read in the same cycle
  task ph2Fall(input logic rd);
    step;
    ph2 <= 1'b1;
    step;
    ph2 <= 1'b0;
    oRd <= rd;
    step;
    oRd <= 1'b0;
    step;
    @(negedge ref_clk);
  endtask

  task tpWrite(input logic [7:0] d);
    step;
    wData <= d;
    tWr <= 1'b1;
    step;
    tWr <= 1'b0;
    @(negedge ref_clk);
  endtask

  task evt(input logic m1, input logic f1, input logic [3:0] xm,
    input logic [3:0] xf);
    step;
    c1Match <= m1;
    fc1 <= f1;
    xMatch <= xm;
    fx <= xf;
    step;
    c1Match <= 1'b0;
    fc1 <= 1'b0;
    xMatch <= 4'h0;
    fx <= 4'h0;
  endtask

  task tRead(input logic [7:0] exp);
    step;
    tRdEn <= 1'b1;
    step;
    tRdEn <= 1'b0;
    @(negedge ref_clk);
    chk({3'h0, tRdData}, exp, "timer read");
  endtask

  task oRead;
    step;
    oRd <= 1'b1;
    step;
    oRd <= 1'b0;
    @(negedge ref_clk);
  endtask

  task oWrite(input logic [7:0] d);
    step;
    wData <= d;
    oWr <= 1'b1;
    step;
    oWr <= 1'b0;
    @(negedge ref_clk);
  endtask

  // general latch drives free lines at the bus clock fall only
  task scenGeneral;
    tpWrite(8'hA8);
    chk({4'h0, tPins}, 8'h00, "lines before strobe");
    eFall;
    chk({4'h0, tPins}, 8'h05, "general lines");
    chk({7'h0, pin7Out}, 8'h01, "line 7 data");
    chk({7'h0, pin7OutEn}, 8'h00, "line 7 released");
    step;
    extEn <= 1'b1;
    extLevel <= 1'b0;
    tRead(8'h05);
  endtask

  // direction acts at phase-2 fall, not at bus clock fall
  task scenDirection;
    step;
    bit7Dir <= 1'b1;
    extEn <= 1'b0;
    eFall;
    chk({7'h0, pin7OutEn}, 8'h00, "enable at bus fall");
    ph2Fall(1'b0);
    chk({7'h0, pin7OutEn}, 8'h01, "enable at ph2 fall");
    tRead(8'h15);
  endtask

  // channel 1 load by match and force, masked lines ignore writes
  task scenChannel1;
    step;
    c1Mask <= 4'h3;
    c1Val <= 4'h2;
    c1m7 <= 1'b1;
    c1v7 <= 1'b1;
    tpWrite(8'h78);
    evt(1'b1, 1'b0, 4'h0, 4'h0);
    eFall;
    chk({4'h0, tPins}, 8'h0E, "channel 1 match");
    chk({7'h0, pin7Out}, 8'h01, "line 7 match");
    tpWrite(8'h00);
    eFall;
    chk({4'h0, tPins}, 8'h02, "masked hold");
    chk({7'h0, pin7Out}, 8'h01, "line 7 write blocked");
    step;
    c1Val <= 4'h1;
    c1v7 <= 1'b0;
    evt(1'b0, 1'b1, 4'h0, 4'h0);
    eFall;
    chk({4'h0, tPins}, 8'h01, "channel 1 force");
    chk({7'h0, pin7Out}, 8'h00, "line 7 force");
    step;
    c1Mask <= 4'h0;
    c1m7 <= 1'b0;
  endtask

  // line 3 toggle, line 4 low, line 5 high, line 6 general
  task scenModes;
    step;
    oMode <= 4'h6;
    oLevel <= 4'h5;
    tpWrite(8'h78);
    evt(1'b0, 1'b0, 4'hF, 4'h0);
    eFall;
    chk({4'h0, tPins}, 8'h0C, "mode match");
    tpWrite(8'h00);
    evt(1'b0, 1'b0, 4'h0, 4'hF);
    eFall;
    chk({4'h0, tPins}, 8'h05, "mode force");
  endtask

  // channel 1 drives 0 while line 3's own channel asks for 1
  task scenPriority;
    step;
    oMode <= 4'h1;
    oLevel <= 4'h1;
    c1Mask <= 4'h1;
    c1Val <= 4'h0;
    evt(1'b1, 1'b0, 4'h1, 4'h0);
    eFall;
    chk({4'h0, tPins}, 8'h00, "channel 1 wins");
    step;
    oMode <= 4'h0;
    oLevel <= 4'h0;
    c1Mask <= 4'h0;
  endtask

  // single-chip latch, read-back and read-cycle deferral
  task scenOutport;
    oWrite(8'h5A);
    chk(oPins, 8'h00, "pins before ph2 fall");
    ph2Fall(1'b0);
    chk(oPins, 8'h5A, "pins after write");
    oRead;
    chk({7'h0, oRdEn}, 8'h01, "read enable");
    chk({7'h0, extAcc}, 8'h00, "no external access");
    chk(oRdData, 8'h5A, "read data");
    oWrite(8'hC3);
    ph2Fall(1'b1);
    chk(oPins, 8'h5A, "held while read");
    chk(oRdData, 8'h5A, "read in fall cycle");
    ph2Fall(1'b0);
    chk(oPins, 8'hC3, "deferred write");
  endtask

  // mid-run reset: latches cleared or set, direction back to input
  task scenReset;
    tpWrite(8'hF8);
    oWrite(8'h99);
    step;
    rst_n <= 1'b0;
    step;
    step;
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk(oPins, 8'h00, "outport after reset");
    chk({pin7OutEn, 2'h0, tRdData}, 8'h00, "line 7 after reset");
    eFall;
    chk({3'h0, pin7Out, tPins}, 8'h00, "general latch cleared");
    ph2Fall(1'b0);
    chk(oPins, 8'h00, "no write after reset");
  endtask

  // expanded mode: address follows strobe, accesses go external
  task scenExpanded;
    step;
    expMode <= 1'b1;
    aStrobe <= 1'b1;
    hiAddr <= 8'h3C;
    step;
    step;
    @(negedge ref_clk);
    chk(oPins, 8'h3C, "address pass");
    step;
    aStrobe <= 1'b0;
    hiAddr <= 8'hC5;
    step;
    step;
    @(negedge ref_clk);
    chk(oPins, 8'h3C, "address hold");
    oRead;
    chk({6'h0, oRdEn, extAcc}, 8'h01, "external read");
    oWrite(8'h11);
    chk({7'h0, extAcc}, 8'h01, "external write");
    ph2Fall(1'b0);
    chk(oPins, 8'h3C, "write kept off pins");
  endtask

  // a hang counts as a failure
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    giveVerdict;
  end

  // reset, then every scenario in turn
  initial begin
    {rst_n, busClk, ph2, tRdEn, tWr, c1m7, c1v7, c1Match, fc1} = 9'h000;
    {bit7Dir, extEn, extLevel, expMode, aStrobe, oWr, oRd} = 7'h00;
    {wData, hiAddr} = 16'h0000;
    {c1Mask, c1Val, oMode, oLevel, xMatch, fx} = 24'h000000;
    errors = 0;
    nTests = 0;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk({pin7Out, pin7OutEn, oRdEn, extAcc, tPins}, 8'h00, "reset");
    chk(oPins, 8'h00, "outport reset");
    step;
    rst_n <= 1'b1;
    scenGeneral;
    scenDirection;
    scenChannel1;
    scenModes;
    scenPriority;
    scenOutport;
    scenReset;
    scenExpanded;
    giveVerdict;
  end
endmodule
`default_nettype wire
